// ==== bench/dlw_layer_regs_properties.sv ====
// Port-level checker of the layer register bank, bound to its top module
`timescale 1ns/100ps
`include "dlw_defines.svh"

module dlw_layer_regs_properties
   import dlw_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   input wire logic              clk,
   input wire logic              rst,
   input wire logic              hsel,
   input wire logic [ADDR_W-1:0] haddr,
   input wire logic [1:0]        htrans,
   input wire logic              hwrite,
   input wire logic [2:0]        hsize,
   input wire logic [31:0]       hwdata,
   input wire logic              hready,
   input wire logic [31:0]       hrdata,
   input wire logic              hreadyout,
   input wire logic              hresp,
   input wire logic              frameStart,
   input wire logic [11:0]       winY,
   input wire logic [11:0]       winWidth,
   input wire logic [12:0]       winHeightLines,
   input wire logic [12:0]       frameHeightLines,
   input wire logic [7:0]        frameStride,
   input wire logic              shownFrame,
   input wire dlw_colour_e       colourMode,
   input wire logic [7:0]        paletteOffset,
   input wire logic              windowPositionEnable,
   input wire logic              overlayExtended,
   input wire logic [25:0]       frameOrigin,
   input wire logic [25:0]       displayAddr
);
   // ****************************************
   // Write tracking
   // ****************************************
   logic        taken;
   logic        wrPhase_reg;
   logic [8:0]  wrIdx_reg;
   logic        colBit_reg;
   logic [1:0]  extCol_reg;
   logic [25:0] org0Exp_reg;
   logic [25:0] org1Exp_reg;
   dlw_colour_e expColour;

   assign taken = hsel && hready && htrans[1] && hsize == `DLW_HSIZE_WORD
                  && haddr[1:0] == 2'h0 && haddr[ADDR_W-1:11] == '0;
   assign expColour = extCol_reg[1] ? DLW_COL_RSVD :
                      extCol_reg[0] ? DLW_COL_DIR24 :
                      colBit_reg ? DLW_COL_DIR16 : DLW_COL_IDX8;

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPhase_reg <= 1'b0;
         wrIdx_reg   <= 9'h0;
         colBit_reg  <= 1'b0;
         extCol_reg  <= 2'h0;
         org0Exp_reg <= 26'h0;
         org1Exp_reg <= 26'h0;
      end
      else
      begin
         wrPhase_reg <= taken && hwrite;
         wrIdx_reg   <= haddr[10:2];
         if (wrPhase_reg && wrIdx_reg == `DLW_IDX_MODE)
            colBit_reg <= hwdata[31];
         if (wrPhase_reg && wrIdx_reg == `DLW_IDX_EXT)
            extCol_reg <= hwdata[31:30];
         if (wrPhase_reg && wrIdx_reg == `DLW_IDX_ORG0)
            org0Exp_reg <= {hwdata[25:4], 4'h0};
         if (wrPhase_reg && wrIdx_reg == `DLW_IDX_ORG1)
            org1Exp_reg <= {hwdata[25:4], 4'h0};
      end
   end

   default clocking @(posedge clk); endclocking
   default disable iff (rst);

   // Data phase of a write to either of two indices
   sequence wrTo(a, b);
      wrPhase_reg && (wrIdx_reg == a || wrIdx_reg == b);
   endsequence

   // ****************************************
   // Properties
   // ****************************************
   AST_BUS_OKAY: assert property (hreadyout && !hresp)
      else $error("slave not ready or not okay");
   AST_WIN_Y: assert property (
      wrTo(`DLW_IDX_WIN_Y, `DLW_IDX_WIN_Y_ALT)
      |-> ##2 winY == 12'($past(hwdata, 2)))
      else $error("window y output wrong");
   AST_WIN_HEIGHT: assert property (
      wrTo(`DLW_IDX_WIN_H, `DLW_IDX_WIN_H_ALT)
      |-> ##2 winHeightLines == 13'($past(hwdata, 2) & 32'hfff) + 13'h1)
      else $error("window height not value plus one");
   AST_FRAME_HEIGHT: assert property (
      wrTo(`DLW_IDX_MODE, `DLW_IDX_MODE)
      |-> ##2 frameHeightLines == 13'($past(hwdata, 2) & 32'hfff) + 13'h1)
      else $error("frame height not value plus one");
   AST_STRIDE: assert property (
      wrTo(`DLW_IDX_MODE, `DLW_IDX_MODE)
      |-> ##2 frameStride == 8'($past(hwdata, 2) >> 16))
      else $error("stride output wrong");
   AST_PALETTE: assert property (
      wrTo(`DLW_IDX_EXT, `DLW_IDX_EXT)
      |-> ##2 paletteOffset == {4'($past(hwdata, 2) >> 20), 4'h0})
      else $error("palette offset not sixteen times base");
   AST_EXT_BITS: assert property (
      wrTo(`DLW_IDX_EXT, `DLW_IDX_EXT) |-> ##2
      {overlayExtended, windowPositionEnable} == 2'($past(hwdata, 2)))
      else $error("extended mode bits wrong");
   AST_COLOUR: assert property (colourMode == $past(expColour))
      else $error("colour mode wrong");
   AST_FRAME_SWITCH: assert property (
      $changed(shownFrame) |-> $past(frameStart, 2))
      else $error("shown frame changed off a frame boundary");
   AST_ORIGIN_LOW: assert property (
      frameOrigin == (shownFrame ? $past(org1Exp_reg)
                                 : $past(org0Exp_reg)))
      else $error("frame origin wrong or low bits not zero");
   AST_DISP_LSB: assert property (
      colourMode == DLW_COL_DIR16 |-> !displayAddr[0])
      else $error("display address lsb set in direct16");
endmodule

bind dlw_layer_regs dlw_layer_regs_properties #(.ADDR_W(ADDR_W))
   dlw_layer_regs_properties_inst (.clk(clk), .rst(rst), .hsel(hsel),
   .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
   .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
   .hreadyout(hreadyout), .hresp(hresp), .frameStart(frameStart),
   .winY(winY), .winWidth(winWidth), .winHeightLines(winHeightLines),
   .frameHeightLines(frameHeightLines), .frameStride(frameStride),
   .shownFrame(shownFrame), .colourMode(colourMode),
   .paletteOffset(paletteOffset),
   .windowPositionEnable(windowPositionEnable),
   .overlayExtended(overlayExtended), .frameOrigin(frameOrigin),
   .displayAddr(displayAddr));

// ==== bench/dlw_layer_regs_tb_top.sv ====
// Self-checking bench of the layer register bank over AHB-Lite
`timescale 1ns/100ps
`include "dlw_defines.svh"

module dlw_layer_regs_tb_top
   import dlw_pkg::*;
;
   logic        clk, rst, hsel, hwrite, hreadyout, hresp, frameStart;
   logic [15:0] haddr;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [31:0] hwdata, hrdata, rd;
   logic [11:0] winY, winWidth;
   logic [12:0] winHeightLines, frameHeightLines;
   logic [7:0]  frameStride, paletteOffset;
   logic        shownFrame, windowPositionEnable, overlayExtended;
   dlw_colour_e colourMode;
   logic [25:0] frameOrigin, displayAddr;
   int          num_errors, check_count, cycles;
   logic [8:0]  idxTab [9] = '{`DLW_IDX_MODE, `DLW_IDX_ORG0, `DLW_IDX_DISP0,
      `DLW_IDX_ORG1, `DLW_IDX_DISP1, `DLW_IDX_WIN_Y, `DLW_IDX_WIN_W,
      `DLW_IDX_WIN_H, `DLW_IDX_EXT};
   logic [31:0] maskTab [9] = '{32'he0ff0fff, 32'h03fffff0, 32'h03ffffff,
      32'h03fffff0, 32'h03ffffff, 32'h00000fff, 32'h00000fff, 32'h00000fff,
      32'hc0f00003};
   logic [31:0] flipTab [6] = '{32'h80000000, 32'ha0000000, 32'hc0000000,
      32'hc0000000, 32'he0000000, 32'h00000000};
   logic        shownTab [6] = '{1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 1'b0};

   dlw_layer_regs dlw_layer_regs_inst (.clk(clk), .rst(rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .frameStart(frameStart),
      .winY(winY), .winWidth(winWidth), .winHeightLines(winHeightLines),
      .frameHeightLines(frameHeightLines), .frameStride(frameStride),
      .shownFrame(shownFrame), .colourMode(colourMode),
      .paletteOffset(paletteOffset),
      .windowPositionEnable(windowPositionEnable),
      .overlayExtended(overlayExtended), .frameOrigin(frameOrigin),
      .displayAddr(displayAddr));

   always #10 clk = ~clk;

   // ****************************************
   // Tasks
   // ****************************************
   task automatic stop_test();
      $display("checks %0d mismatches %0d", check_count, num_errors);
      if (num_errors == 0 && check_count > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] exp,
                      input logic [31:0] got);
      check_count++;
      if (got !== exp)
      begin
         num_errors++;
         $display("mismatch %s expected %h seen %h", nm, exp, got);
      end
   endtask

   // Read data is taken at the rising edge that ends the data phase
   task automatic xfer(input logic wr, input logic [8:0] i,
                       input logic [31:0] wd);
      @(posedge clk);
      hsel   <= 1'b1;
      haddr  <= {5'h0, i, 2'h0};
      htrans <= `DLW_HTRANS_NONSEQ;
      hwrite <= wr;
      hsize  <= `DLW_HSIZE_WORD;
      do @(posedge clk);
      while (hreadyout !== 1'b1);
      hsel   <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk);
      while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask

   task automatic rdChk(input logic [8:0] i, input logic [31:0] exp);
      xfer(1'b0, i, 32'h0);
      chk($sformatf("register %h", i), exp, rd);
   endtask

   // Derived outputs land one edge after the data phase
   task automatic settle();
      @(posedge clk);
      @(negedge clk);
   endtask

   task automatic pulse();
      @(posedge clk) frameStart <= 1'b1;
      @(posedge clk) frameStart <= 1'b0;
      settle();
   endtask

   always @(posedge clk)
   begin
      cycles++;
      if (cycles > 5000)
      begin
         num_errors++;
         stop_test();
      end
   end

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      {clk, hsel, hwrite, frameStart, haddr, htrans, hsize} = '0;
      {hwdata, num_errors, check_count, cycles} = '0;
      rst = 1'b1;
      repeat (4) @(posedge clk);
      rst <= 1'b0;
      for (int k = 0; k < 9; k++)
         rdChk(idxTab[k], 32'h0);
      for (int k = 0; k < 9; k++)
      begin
         xfer(1'b1, idxTab[k], 32'hffffffff);
         rdChk(idxTab[k], maskTab[k]);
      end
      xfer(1'b1, 9'h001, 32'h12345678);
      rdChk(9'h001, 32'h0);
      xfer(1'b1, `DLW_IDX_WIN_Y_ALT, 32'h0000007b);
      rdChk(`DLW_IDX_WIN_Y, 32'h0000007b);
      xfer(1'b1, `DLW_IDX_WIN_W, 32'h00000001);
      rdChk(`DLW_IDX_WIN_W_ALT, 32'h00000001);
      xfer(1'b1, `DLW_IDX_WIN_H_ALT, 32'h00000fff);
      rdChk(`DLW_IDX_WIN_H, 32'h00000fff);
      settle();
      chk("winY", 32'(winY), 32'h7b);
      chk("winWidth", 32'(winWidth), 32'h1);
      chk("winHeightLines", 32'(winHeightLines), 32'h1000);
      xfer(1'b1, `DLW_IDX_MODE, 32'h00a50fff);
      xfer(1'b1, `DLW_IDX_EXT, 32'h40f00003);
      settle();
      chk("frameHeightLines", 32'(frameHeightLines), 32'h1000);
      chk("frameStride", 32'(frameStride), 32'ha5);
      chk("colourMode", 32'(colourMode), 32'(DLW_COL_DIR24));
      chk("paletteOffset", 32'(paletteOffset), 32'hf0);
      chk("wpos", 32'(windowPositionEnable), 32'h1);
      chk("overlay", 32'(overlayExtended), 32'h1);
      xfer(1'b1, `DLW_IDX_EXT, 32'h00500000);
      settle();
      chk("colourMode", 32'(colourMode), 32'(DLW_COL_IDX8));
      chk("wpos", 32'(windowPositionEnable), 32'h0);
      chk("paletteOffset", 32'(paletteOffset), 32'h50);
      chk("overlay", 32'(overlayExtended), 32'h0);
      xfer(1'b1, `DLW_IDX_ORG0, 32'h00001234);
      xfer(1'b1, `DLW_IDX_ORG1, 32'h00004567);
      xfer(1'b1, `DLW_IDX_DISP0, 32'h00000011);
      xfer(1'b1, `DLW_IDX_DISP1, 32'h00000023);
      for (int k = 0; k < 6; k++)
      begin
         xfer(1'b1, `DLW_IDX_MODE, flipTab[k]);
         settle();
         if (k == 1)
            chk("held frame", 32'(shownFrame), 32'h0);
         pulse();
         chk("shownFrame", 32'(shownFrame), 32'(shownTab[k]));
         chk("colourMode", 32'(colourMode), flipTab[k][31] ?
             32'(DLW_COL_DIR16) : 32'(DLW_COL_IDX8));
         chk("frameOrigin", 32'(frameOrigin),
             shownTab[k] ? 32'h4560 : 32'h1230);
         chk("displayAddr", 32'(displayAddr), (shownTab[k] ? 32'h23 :
             32'h11) & ~32'(flipTab[k][31]));
      end
      stop_test();
   end
endmodule

// ==== core/dlw_defines.svh ====
// Register offsets, field positions and codes of the layer registers
`ifndef DLW_DEFINES_SVH
`define DLW_DEFINES_SVH

// Word indices; the byte address is four times the index
`define DLW_IDX_MODE        9'h040
`define DLW_IDX_ORG0        9'h044
`define DLW_IDX_DISP0       9'h048
`define DLW_IDX_ORG1        9'h04c
`define DLW_IDX_DISP1       9'h050
`define DLW_IDX_WIN_Y       9'h126
`define DLW_IDX_WIN_W       9'h128
`define DLW_IDX_WIN_H       9'h12a
`define DLW_IDX_EXT         9'h130
`define DLW_IDX_WIN_Y_ALT   9'h01a
`define DLW_IDX_WIN_W_ALT   9'h01c
`define DLW_IDX_WIN_H_ALT   9'h01e
`define DLW_IDX_W           9

// Window registers
`define DLW_WIN_W           12

// Mode register fields
`define DLW_HGT_LSB         0
`define DLW_HGT_W           12
`define DLW_STR_LSB         16
`define DLW_STR_W           8
`define DLW_FLP_LSB         29
`define DLW_FLP_W           2
`define DLW_COL_BIT         31

// Extended mode fields
`define DLW_WP_BIT          0
`define DLW_OM_BIT          1
`define DLW_PB_LSB          20
`define DLW_PB_W            4
`define DLW_EC_LSB          30
`define DLW_EC_W            2
`define DLW_PB_SHIFT        4

// Address registers
`define DLW_ORG_LSB         4
`define DLW_ADR_W           26

// Flip select codes
`define DLW_FLP_F0          2'h0
`define DLW_FLP_F1          2'h1
`define DLW_FLP_ALT         2'h2

// Extended colour codes
`define DLW_EC_BASIC        2'h0
`define DLW_EC_DIRECT24     2'h1

// AHB codes
`define DLW_HTRANS_NONSEQ   2'h2
`define DLW_HTRANS_SEQ      2'h3
`define DLW_HSIZE_WORD      3'h2

`endif

// ==== core/dlw_layer_regs.sv ====
// Layer window and mode registers behind an AHB-Lite slave port
`timescale 1ns/100ps
`include "dlw_defines.svh"

module dlw_layer_regs
   import dlw_pkg::*;
#(
   parameter int ADDR_W = 16
)
(
   input  wire logic                     clk,
   input  wire logic                     rst,
   input  wire logic                     hsel,
   input  wire logic [ADDR_W-1:0]        haddr,
   input  wire logic [1:0]               htrans,
   input  wire logic                     hwrite,
   input  wire logic [2:0]               hsize,
   input  wire logic [31:0]              hwdata,
   input  wire logic                     hready,
   output logic [31:0]                   hrdata,
   output logic                          hreadyout,
   output logic                          hresp,
   input  wire logic                     frameStart,
   output logic [`DLW_WIN_W-1:0]         winY,
   output logic [`DLW_WIN_W-1:0]         winWidth,
   output logic [`DLW_WIN_W:0]           winHeightLines,
   output logic [`DLW_HGT_W:0]           frameHeightLines,
   output logic [`DLW_STR_W-1:0]         frameStride,
   output logic                          shownFrame,
   output dlw_colour_e                   colourMode,
   output logic [`DLW_STR_W-1:0]         paletteOffset,
   output logic                          windowPositionEnable,
   output logic                          overlayExtended,
   output logic [`DLW_ADR_W-1:0]         frameOrigin,
   output logic [`DLW_ADR_W-1:0]         displayAddr
);

   // ****************************************************************
   // Elaboration checks
   // ****************************************************************
   // Highest index needs the word address to reach bit 10
   if (ADDR_W < `DLW_IDX_W + 2 || ADDR_W > 32)
   begin : gBadAddrW
      $error("ADDR_W cannot reach the register map");
   end

   // ****************************************************************
   // Storage
   // ****************************************************************
   logic [`DLW_WIN_W-1:0]               winY_reg;
   logic [`DLW_WIN_W-1:0]               winW_reg;
   logic [`DLW_WIN_W-1:0]               winH_reg;
   logic [`DLW_HGT_W-1:0]               hgt_reg;
   logic [`DLW_STR_W-1:0]               stride_reg;
   logic [`DLW_FLP_W-1:0]               flip_reg;
   logic                                colour_reg;
   logic [`DLW_EC_W-1:0]                extCol_reg;
   logic [`DLW_PB_W-1:0]                palBase_reg;
   logic                                overlay_reg;
   logic                                winPos_reg;
   logic [`DLW_ADR_W-1:`DLW_ORG_LSB]    org0_reg;
   logic [`DLW_ADR_W-1:`DLW_ORG_LSB]    org1_reg;
   logic [`DLW_ADR_W-1:0]               disp0_reg;
   logic [`DLW_ADR_W-1:0]               disp1_reg;
   logic                                frame_reg;
   logic                                frame_next;

   // ****************************************************************
   // AHB-Lite address and data phase
   // ****************************************************************
   // Write data follows its address by one cycle, so the target is kept
   logic                                wrPend_reg;
   logic [`DLW_IDX_W-1:0]               wrIdx_reg;
   logic [31:0]                         rdData_reg;
   logic [31:0]                         rdData_next;
   wire                                 addrValid;
   wire  [`DLW_IDX_W-1:0]               addrIdx;
   wire  [`DLW_IDX_W-1:0]               wIdx;
   wire                                 highZero;

   // Only whole aligned words are served; anything else is ignored
   // Upper address bits must be clear, else the map would repeat
   assign highZero  = (haddr[ADDR_W-1:2] >> `DLW_IDX_W) == '0;
   assign addrValid = hsel && hready && htrans[1]
                      && hsize == `DLW_HSIZE_WORD
                      && haddr[1:0] == 2'h0 && highZero;
   assign addrIdx   = haddr[`DLW_IDX_W+1:2];
   assign wIdx      = wrIdx_reg;

   // Each window register answers at its primary and its alias index
   wire wrY    = wrPend_reg && (wIdx == `DLW_IDX_WIN_Y
                 || wIdx == `DLW_IDX_WIN_Y_ALT);
   wire wrW    = wrPend_reg && (wIdx == `DLW_IDX_WIN_W
                 || wIdx == `DLW_IDX_WIN_W_ALT);
   wire wrH    = wrPend_reg && (wIdx == `DLW_IDX_WIN_H
                 || wIdx == `DLW_IDX_WIN_H_ALT);
   wire wrMode = wrPend_reg && wIdx == `DLW_IDX_MODE;
   wire wrExt  = wrPend_reg && wIdx == `DLW_IDX_EXT;
   wire wrOrg0 = wrPend_reg && wIdx == `DLW_IDX_ORG0;
   wire wrOrg1 = wrPend_reg && wIdx == `DLW_IDX_ORG1;
   wire wrDsp0 = wrPend_reg && wIdx == `DLW_IDX_DISP0;
   wire wrDsp1 = wrPend_reg && wIdx == `DLW_IDX_DISP1;

   // Read words assembled here; reserved bits stay zero
   wire [31:0] rdWinY = {20'h0, winY_reg};
   wire [31:0] rdWinW = {20'h0, winW_reg};
   wire [31:0] rdWinH = {20'h0, winH_reg};
   wire [31:0] rdMode = {colour_reg, flip_reg, 5'h0, stride_reg,
                         4'h0, hgt_reg};
   wire [31:0] rdExt  = {extCol_reg, 6'h0, palBase_reg, 18'h0,
                         overlay_reg, winPos_reg};
   wire [31:0] rdOrg0 = {6'h0, org0_reg, 4'h0};
   wire [31:0] rdOrg1 = {6'h0, org1_reg, 4'h0};
   wire [31:0] rdDsp0 = {6'h0, disp0_reg};
   wire [31:0] rdDsp1 = {6'h0, disp1_reg};

   // Read data is fetched in the address phase: a read right behind a
   // write to the same word sees the old value unless a cycle passes
   always_comb
   begin
      rdData_next = 32'h0;
      if (addrValid && !hwrite)
      begin
         case (addrIdx)
            `DLW_IDX_WIN_Y,
            `DLW_IDX_WIN_Y_ALT: rdData_next = rdWinY;
            `DLW_IDX_WIN_W,
            `DLW_IDX_WIN_W_ALT: rdData_next = rdWinW;
            `DLW_IDX_WIN_H,
            `DLW_IDX_WIN_H_ALT: rdData_next = rdWinH;
            `DLW_IDX_MODE:      rdData_next = rdMode;
            `DLW_IDX_EXT:       rdData_next = rdExt;
            `DLW_IDX_ORG0:      rdData_next = rdOrg0;
            `DLW_IDX_ORG1:      rdData_next = rdOrg1;
            `DLW_IDX_DISP0:     rdData_next = rdDsp0;
            `DLW_IDX_DISP1:     rdData_next = rdDsp1;
            default:            rdData_next = 32'h0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         wrPend_reg <= 1'b0;
         wrIdx_reg  <= '0;
         rdData_reg <= 32'h0;
      end
      else
      begin
         wrPend_reg <= addrValid && hwrite;
         wrIdx_reg  <= addrIdx;
         rdData_reg <= rdData_next;
      end
   end

   // Zero wait states, OKAY only
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
      else
      begin
         hreadyout <= 1'b1;
         hresp     <= 1'b0;
      end
   end

   assign hrdata = rdData_reg;

   // ****************************************************************
   // Register writes
   // ****************************************************************
   // Zero width is forbidden to software and is stored as written
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         winY_reg <= '0;
         winW_reg <= '0;
         winH_reg <= '0;
      end
      else
      begin
         if (wrY)
            winY_reg <= hwdata[`DLW_WIN_W-1:0];
         if (wrW)
            winW_reg <= hwdata[`DLW_WIN_W-1:0];
         if (wrH)
            winH_reg <= hwdata[`DLW_WIN_W-1:0];
      end
   end

   // Reserved mode bits have no storage and read back as zero
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         hgt_reg    <= '0;
         stride_reg <= '0;
         flip_reg   <= `DLW_FLP_F0;
         colour_reg <= 1'b0;
      end
      else if (wrMode)
      begin
         hgt_reg    <= hwdata[`DLW_HGT_LSB +: `DLW_HGT_W];
         stride_reg <= hwdata[`DLW_STR_LSB +: `DLW_STR_W];
         flip_reg   <= hwdata[`DLW_FLP_LSB +: `DLW_FLP_W];
         colour_reg <= hwdata[`DLW_COL_BIT];
      end
   end

   // Extended mode starts defined so the layer never blends at random
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         extCol_reg  <= '0;
         palBase_reg <= '0;
         overlay_reg <= 1'b0;
         winPos_reg  <= 1'b0;
      end
      else if (wrExt)
      begin
         extCol_reg  <= hwdata[`DLW_EC_LSB +: `DLW_EC_W];
         palBase_reg <= hwdata[`DLW_PB_LSB +: `DLW_PB_W];
         overlay_reg <= hwdata[`DLW_OM_BIT];
         winPos_reg  <= hwdata[`DLW_WP_BIT];
      end
   end

   // Origins keep no low bits, so their alignment cannot be broken
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         org0_reg  <= '0;
         org1_reg  <= '0;
         disp0_reg <= '0;
         disp1_reg <= '0;
      end
      else
      begin
         if (wrOrg0)
            org0_reg <= hwdata[`DLW_ADR_W-1:`DLW_ORG_LSB];
         if (wrOrg1)
            org1_reg <= hwdata[`DLW_ADR_W-1:`DLW_ORG_LSB];
         if (wrDsp0)
            disp0_reg <= hwdata[`DLW_ADR_W-1:0];
         if (wrDsp1)
            disp1_reg <= hwdata[`DLW_ADR_W-1:0];
      end
   end

   // ****************************************************************
   // Frame selection
   // ****************************************************************
   // Changing frames mid-scan would tear the picture
   // Fixed frame choices also wait for the boundary
   // Reserved flip code falls back to frame 0
   always_comb
   begin
      frame_next = frame_reg;
      // One-cycle pulse at each frame boundary
      if (frameStart)
      begin
         case (flip_reg)
            `DLW_FLP_F0:  frame_next = 1'b0;
            `DLW_FLP_F1:  frame_next = 1'b1;
            `DLW_FLP_ALT: frame_next = ~frame_reg;
            default:      frame_next = 1'b0;
         endcase
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         frame_reg <= 1'b0;
      else
         frame_reg <= frame_next;
   end

   // ****************************************************************
   // Derived outputs
   // ****************************************************************
   // Every output is a flop and lags its source register by one clock
   dlw_colour_e colour_next;
   wire         dir16;
   wire [`DLW_ADR_W-1:0] dispSel;
   wire [`DLW_ADR_W-1:0] dispEff;
   wire [`DLW_ADR_W-1:0] orgSel;

   // Reserved extended colour codes are reported, not hidden
   always_comb
   begin
      case (extCol_reg)
         `DLW_EC_BASIC:    colour_next = colour_reg ? DLW_COL_DIR16
                                         : DLW_COL_IDX8;
         `DLW_EC_DIRECT24: colour_next = DLW_COL_DIR24;
         default:          colour_next = DLW_COL_RSVD;
      endcase
   end

   assign dir16   = colour_next == DLW_COL_DIR16;
   assign dispSel = frame_reg ? disp1_reg : disp0_reg;
   // Stored address reads back as written; only the output drops bit 0, and only in direct16 mode
   assign dispEff = {dispSel[`DLW_ADR_W-1:1],
                     dispSel[0] & ~dir16};
   assign orgSel  = frame_reg ? {org1_reg, {`DLW_ORG_LSB{1'b0}}}
                              : {org0_reg, {`DLW_ORG_LSB{1'b0}}};

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         winY                 <= '0;
         winWidth             <= '0;
         winHeightLines       <= '0;
         frameHeightLines     <= '0;
         frameStride          <= '0;
         shownFrame           <= 1'b0;
         colourMode           <= DLW_COL_IDX8;
         paletteOffset        <= '0;
         windowPositionEnable <= 1'b0;
         overlayExtended      <= 1'b0;
         frameOrigin          <= '0;
         displayAddr          <= '0;
      end
      else
      begin
         winY                 <= winY_reg;
         winWidth             <= winW_reg;
         winHeightLines       <= {1'b0, winH_reg}
                                 + {{`DLW_WIN_W{1'b0}}, 1'b1};
         frameHeightLines     <= {1'b0, hgt_reg}
                                 + {{`DLW_HGT_W{1'b0}}, 1'b1};
         frameStride          <= stride_reg;
         shownFrame           <= frame_reg;
         colourMode           <= colour_next;
         paletteOffset        <= {palBase_reg,
                                  {`DLW_PB_SHIFT{1'b0}}};
         windowPositionEnable <= winPos_reg;
         overlayExtended      <= overlay_reg;
         frameOrigin          <= orgSel;
         displayAddr          <= dispEff;
      end
   end

endmodule

// ==== core/dlw_pkg.sv ====
// Types shared by the layer register bank
package dlw_pkg;
   typedef enum logic [1:0] {
      DLW_COL_IDX8,
      DLW_COL_DIR16,
      DLW_COL_DIR24,
      DLW_COL_RSVD
   } dlw_colour_e;
endpackage
